// ---- hdl/pdid_pkg.sv ----
package pdid_pkg;
  // Register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_IDCFG = 8'h04;
  localparam logic [7:0] REG_CERT = 8'h08;
  localparam logic [7:0] REG_PROD = 8'h0C;
  localparam logic [7:0] REG_ADAPT = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_PARTNER = 8'h18;
  // Control bit positions
  localparam int CTRL_START = 0;
  localparam int CTRL_CABLE = 1;
  localparam int CTRL_EXPL = 2;
  localparam int CTRL_RSPEN = 3;
  // Reset values
  localparam logic [31:0] IDCFG_RST = 32'h0000_0000;
  localparam logic [3:0] CTRL_RST = 4'h0;
  // Structured header fields
  localparam logic [1:0] CT_INIT = 2'h0;
  localparam logic [1:0] CT_ACK = 2'h1;
  localparam logic [1:0] CT_NAK = 2'h2;
  localparam logic [1:0] CT_BUSY = 2'h3;
  localparam logic [4:0] CMD_DISC_ID = 5'h01;
  localparam logic [4:0] CMD_ATTN = 5'h06;
  // Identity header type codes
  localparam logic [2:0] UFP_ADAPTER = 3'h5;
  localparam logic [2:0] DFP_MAX = 3'h4;
  // Object counts
  localparam logic [2:0] NDO_REQ = 3'h1;
  localparam logic [2:0] NDO_ACK = 3'h4;
  // Discovery outcome codes
  localparam logic [2:0] RES_NONE = 3'h0;
  localparam logic [2:0] RES_ACK = 3'h1;
  localparam logic [2:0] RES_NAK = 3'h2;
  localparam logic [2:0] RES_NOCRC = 3'h3;
  localparam logic [2:0] RES_TMO = 3'h4;
  // Timing
  localparam int CLK_NS = 25;
  localparam int SETTLE_TIME_US = 50;
  localparam int RETRY_TIME_US = 45;
  localparam int BUSY_TIME_US = 50;
  localparam int SETTLE_CYC = (SETTLE_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int RETRY_CYC = (RETRY_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int BUSY_CYC = (BUSY_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int RETRY_LIMIT = 20;

  typedef struct packed {
    logic cable;
    logic [2:0] ndo;
    logic last;
    logic [31:0] data;
  } pdid_tx_t;

  typedef struct packed {
    logic cable;
    logic [2:0] ndo;
    logic [31:0] vdm;
    logic [31:0] obj1;
  } pdid_rx_t;

  // Structured header: SVID, structured flag, version 0, position 0
  function automatic logic [31:0] mk_vdm(logic [15:0] svid, logic [1:0] ct, logic [4:0] cmd);
    mk_vdm = {svid, 1'b1, 2'b00, 2'b00, 3'b000, ct, 1'b0, cmd};
  endfunction
endpackage

// ---- hdl/pdid_timer.sv ----
module pdid_timer import pdid_pkg::*; #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Control
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic done
);
  logic [W-1:0] cnt_q;

  // Down counter, reload wins
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= load_val;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign done = (cnt_q == '0) && !load;
endmodule // pdid_timer

// ---- hdl/pdid_idhdr.sv ----
module pdid_idhdr import pdid_pkg::*; (
  // Raw software configuration
  input wire logic [31:0] cfg,
  // Cleaned identity header
  output logic [31:0] hdr,
  output logic has_ptype
);
  wire [2:0] ufp_raw = cfg[29:27];
  wire [2:0] dfp_raw = cfg[25:23];
  // Reserved codes fall back to undefined
  wire ufp_ok = (ufp_raw <= 3'h2) || (ufp_raw == UFP_ADAPTER);
  wire dfp_ok = (dfp_raw <= DFP_MAX);
  wire [2:0] ufp = ufp_ok ? ufp_raw : 3'h0;
  wire [2:0] dfp = dfp_ok ? dfp_raw : 3'h0;

  // Host, device, modal flags, vendor id; reserved field zero
  assign hdr = {cfg[31], cfg[30], ufp, cfg[26], dfp, 7'h00, cfg[15:0]};
  // Only the adapter type defines a product-type object
  assign has_ptype = (ufp == UFP_ADAPTER);
endmodule // pdid_idhdr

// ---- hdl/pdid_top.sv ----
// The plain strobed port and the placing of the registers were chosen for this implementation.
module pdid_top import pdid_pkg::*; #(
  parameter logic [15:0] PROTO_SID = 16'hA5C3, // Arbitrary value
  parameter int SETTLE_CYCLES = SETTLE_CYC,
  parameter int RETRY_CYCLES = RETRY_CYC,
  parameter int BUSY_CYCLES = BUSY_CYC,
  parameter int LIMIT = RETRY_LIMIT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Transmit beats to the message layer
  output logic tx_valid,
  input wire logic tx_ready,
  output pdid_tx_t tx_beat,
  input wire logic tx_crc_ok,
  input wire logic tx_crc_fail,
  // Received structured messages
  input wire logic rx_valid,
  input wire pdid_rx_t rx_msg,
  input wire logic rsp_crc_sent,
  // Cable supply and reset request
  input wire logic cable_supply_on,
  output logic soft_reset_req
);
  typedef enum logic [1:0] {T_IDLE, T_SEND, T_CRC} pdid_tx_st_t;
  typedef enum logic [2:0] {I_IDLE, I_SETTLE, I_SEND, I_CRC, I_RESP, I_ACKCRC, I_GAP} pdid_ini_t;
  typedef enum logic [1:0] {M_REQ, M_ACK, M_NAK} pdid_kind_t;
  logic [3:0] ctrl_q;
  logic [4:0] rcmd_q;
  logic [31:0] idcfg_q, cert_q, prod_q, adapt_q, partner_q, rdata_q;
  pdid_tx_st_t tst_q;
  pdid_ini_t ist_q;
  pdid_kind_t kind_q, rkind_q;
  logic rsp_pend_q, src_ini_q, cable_q, tgt_cable_q, soft_q;
  logic [2:0] idx_q, ndo_q, result_q;
  logic [31:0] txd_q;
  logic [7:0] tries_q;
  logic [1:0] rct_q;
  logic [31:0] robj_q;
  logic [31:0] id_hdr;
  logic has_ptype, settled_raw, tmr_done, tmr_load;
  logic [15:0] tmr_val;

  // Identity header and timers
  pdid_idhdr u_idhdr (
    .cfg(idcfg_q),
    .hdr(id_hdr),
    .has_ptype(has_ptype)
  );
  pdid_timer #(.W(16)) u_settle (
    .clk(clk),
    .reset_n(reset_n),
    .load(!cable_supply_on),
    .load_val(16'(SETTLE_CYCLES)),
    .done(settled_raw)
  );
  pdid_timer #(.W(16)) u_tmr (
    .clk(clk),
    .reset_n(reset_n),
    .load(tmr_load),
    .load_val(tmr_val),
    .done(tmr_done)
  );

  // Register write decode
  wire wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
  wire start_p = wr_ctrl && reg_wdata[CTRL_START] && (ist_q == I_IDLE);
  wire settled = settled_raw && cable_supply_on;

  // Received message decode; object count beyond header is never examined
  wire [15:0] rx_svid = rx_msg.vdm[31:16];
  wire [1:0] rx_ct = rx_msg.vdm[7:6];
  wire [4:0] rx_cmd = rx_msg.vdm[4:0];
  wire rx_req = rx_valid && !rx_msg.cable && (rx_ct == CT_INIT)
      && ctrl_q[CTRL_RSPEN] && (rx_cmd != CMD_ATTN);
  wire rx_id_ok = (rx_cmd == CMD_DISC_ID) && (rx_svid == PROTO_SID) && idcfg_q[26];
  wire rx_rsp = rx_valid && (rx_ct != CT_INIT) && (rx_cmd == CMD_DISC_ID)
      && (rx_msg.cable == tgt_cable_q);

  // Message words: header object, identity, certification, product, adapter
  wire [31:0] w_req = mk_vdm(PROTO_SID, CT_INIT, CMD_DISC_ID);
  wire [31:0] w_ack = mk_vdm(PROTO_SID, CT_ACK, CMD_DISC_ID);
  wire [31:0] w_nak = mk_vdm(PROTO_SID, CT_NAK, rcmd_q);
  logic [31:0] ack_w [0:4];
  assign ack_w = '{w_ack, id_hdr, cert_q, prod_q, adapt_q};
  wire [2:0] ack_ndo = NDO_ACK + {2'b00, has_ptype};
  // Transmit engine start; responder has priority
  wire start_rsp = (tst_q == T_IDLE) && rsp_pend_q;
  wire start_ini = (tst_q == T_IDLE) && !rsp_pend_q && (ist_q == I_SEND);
  wire beat_last = (idx_q == ndo_q - 3'h1);
  wire [2:0] idx_n = idx_q + 3'h1;
  wire crc_done = (tst_q == T_CRC) && (tx_crc_ok || tx_crc_fail);
  wire ini_crc_ok = crc_done && src_ini_q && tx_crc_ok;
  wire ini_crc_fail = crc_done && src_ini_q && !tx_crc_ok;
  wire can_retry = tgt_cable_q && ctrl_q[CTRL_EXPL] && (tries_q < 8'(LIMIT));

  assign tx_valid = (tst_q == T_SEND);
  assign tx_beat = '{cable: cable_q, ndo: ndo_q, last: beat_last, data: txd_q};
  assign soft_reset_req = soft_q;
  assign reg_rdata = rdata_q;

  // Register file
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= CTRL_RST;
      idcfg_q <= IDCFG_RST;
      cert_q <= '0;
      prod_q <= '0;
      adapt_q <= '0;
    end else if (reg_wr) begin
      if (reg_addr == REG_CTRL) begin
        ctrl_q <= {reg_wdata[3:1], 1'b0};
      end else if (reg_addr == REG_IDCFG) begin
        idcfg_q <= reg_wdata;
      end else if (reg_addr == REG_CERT) begin
        cert_q <= reg_wdata;
      end else if (reg_addr == REG_PROD) begin
        prod_q <= reg_wdata;
      end else if (reg_addr == REG_ADAPT) begin
        adapt_q <= reg_wdata;
      end
    end
  end

  // Read mux; unmapped addresses read zero
  wire [31:0] status_w = {16'h0000, tries_q, (ist_q != I_IDLE), result_q, settled, 3'b000};
  wire [31:0] rmux = (reg_addr == REG_CTRL) ? {28'h000_0000, ctrl_q} :
      (reg_addr == REG_IDCFG) ? idcfg_q :
      (reg_addr == REG_CERT) ? cert_q :
      (reg_addr == REG_PROD) ? prod_q :
      (reg_addr == REG_ADAPT) ? adapt_q :
      (reg_addr == REG_STATUS) ? status_w :
      (reg_addr == REG_PARTNER) ? partner_q : 32'h0000_0000;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= reg_rd ? rmux : 32'h0000_0000;
    end
  end

  // Responder: queue acknowledge or negative acknowledge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rsp_pend_q <= 1'b0;
      rkind_q <= M_NAK;
      rcmd_q <= '0;
    end else if (rx_req) begin
      rsp_pend_q <= 1'b1;
      rcmd_q <= rx_cmd;
      rkind_q <= rx_id_ok ? M_ACK : M_NAK;
    end else if (start_rsp) begin
      rsp_pend_q <= 1'b0;
    end
  end
  // Transmit engine
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tst_q <= T_IDLE;
      kind_q <= M_REQ;
      src_ini_q <= 1'b0;
      cable_q <= 1'b0;
      idx_q <= '0;
      ndo_q <= NDO_REQ;
      txd_q <= '0;
    end else begin
      case (tst_q)
        T_IDLE: begin
          idx_q <= '0;
          if (start_rsp) begin
            tst_q <= T_SEND;
            kind_q <= rkind_q;
            src_ini_q <= 1'b0;
            cable_q <= 1'b0;
            ndo_q <= (rkind_q == M_ACK) ? ack_ndo : NDO_REQ;
            txd_q <= (rkind_q == M_ACK) ? w_ack : w_nak;
          end else if (start_ini) begin
            tst_q <= T_SEND;
            kind_q <= M_REQ;
            src_ini_q <= 1'b1;
            cable_q <= tgt_cable_q;
            ndo_q <= NDO_REQ;
            txd_q <= w_req;
          end
        end
        T_SEND: begin
          if (tx_ready && beat_last) begin
            tst_q <= T_CRC;
          end else if (tx_ready) begin
            idx_q <= idx_n;
            txd_q <= ack_w[idx_n];
          end
        end
        default: begin
          if (tx_crc_ok || tx_crc_fail) begin
            tst_q <= T_IDLE;
          end
        end
      endcase
    end
  end

  // Initiator timer loads
  always_comb begin
    tmr_load = 1'b0;
    tmr_val = 16'(RETRY_CYCLES);
    if ((ist_q == I_CRC) && ini_crc_ok) begin
      tmr_load = 1'b1;
    end else if ((ist_q == I_CRC) && ini_crc_fail && can_retry) begin
      tmr_load = 1'b1;
    end else if ((ist_q == I_RESP) && rx_rsp) begin
      tmr_load = 1'b1;
    end else if ((ist_q == I_RESP) && tmr_done && can_retry) begin
      tmr_load = 1'b1;
    end else if ((ist_q == I_ACKCRC) && rsp_crc_sent && (rct_q == CT_BUSY)) begin
      tmr_load = 1'b1;
      tmr_val = 16'(BUSY_CYCLES);
    end
  end

  // Initiator sequence
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ist_q <= I_IDLE;
      tgt_cable_q <= 1'b0;
      tries_q <= '0;
      result_q <= RES_NONE;
      soft_q <= 1'b0;
      rct_q <= CT_INIT;
      robj_q <= '0;
      partner_q <= '0;
    end else begin
      soft_q <= 1'b0;
      case (ist_q)
        I_IDLE: begin
          if (start_p) begin
            tgt_cable_q <= reg_wdata[CTRL_CABLE];
            tries_q <= '0;
            result_q <= RES_NONE;
            ist_q <= reg_wdata[CTRL_CABLE] ? I_SETTLE : I_SEND;
          end
        end
        I_SETTLE: begin
          if (settled) begin
            ist_q <= I_SEND;
          end
        end
        I_SEND: begin
          if (start_ini) begin
            tries_q <= tries_q + 8'h01;
            ist_q <= I_CRC;
          end
        end
        I_CRC: begin
          if (ini_crc_ok) begin
            ist_q <= I_RESP;
          end else if (ini_crc_fail) begin
            soft_q <= !tgt_cable_q;
            result_q <= RES_NOCRC;
            ist_q <= can_retry ? I_GAP : I_IDLE;
          end
        end
        I_RESP: begin
          if (rx_rsp) begin
            rct_q <= rx_ct;
            robj_q <= rx_msg.obj1;
            ist_q <= I_ACKCRC;
          end else if (tmr_done) begin
            result_q <= RES_TMO;
            ist_q <= can_retry ? I_GAP : I_IDLE;
          end
        end
        I_ACKCRC: begin
          if (rsp_crc_sent && (rct_q == CT_BUSY)) begin
            ist_q <= I_GAP;
          end else if (rsp_crc_sent) begin
            result_q <= (rct_q == CT_ACK) ? RES_ACK : RES_NAK;
            if (rct_q == CT_ACK) begin
              partner_q <= robj_q;
            end
            ist_q <= I_IDLE;
          end else if (tmr_done) begin
            result_q <= RES_TMO;
            ist_q <= I_IDLE;
          end
        end
        default: begin
          if (tmr_done) begin
            ist_q <= tgt_cable_q ? I_SETTLE : I_SEND;
          end
        end
      endcase
    end
  end
  // Checks
  sequence busy_done_s;
    (ist_q == I_ACKCRC) && rsp_crc_sent && (rct_q == CT_BUSY);
  endsequence
  sequence quiet_s;
    !start_ini [*8];
  endsequence
  no_soft_cable_a: assert property (@(posedge clk) disable iff (!reset_n)
    (ini_crc_fail && tgt_cable_q) |=> !soft_reset_req)
    else $error("soft reset after cable probe");
  settle_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
    (start_ini && tgt_cable_q) |-> settled)
    else $error("cable probed before settle");
  retry_bound_a: assert property (@(posedge clk) disable iff (!reset_n)
    (ist_q == I_GAP) |-> (tries_q <= 8'(LIMIT)) && (tries_q != 8'h00))
    else $error("retry count out of range");
  req_svid_a: assert property (@(posedge clk) disable iff (!reset_n)
    (tx_valid && kind_q == M_REQ) |-> (tx_beat.data[31:16] == PROTO_SID))
    else $error("request svid wrong");
  req_ndo_a: assert property (@(posedge clk) disable iff (!reset_n)
    (tx_valid && kind_q == M_REQ) |-> (tx_beat.ndo == NDO_REQ) && tx_beat.last)
    else $error("request object count wrong");
  ack_ndo_a: assert property (@(posedge clk) disable iff (!reset_n)
    (tx_valid && kind_q == M_ACK) |-> (tx_beat.ndo == ack_ndo) && (tx_beat.ndo >= NDO_ACK))
    else $error("ack object count wrong");
  ack_answer_a: assert property (@(posedge clk) disable iff (!reset_n)
    (rx_req && rx_id_ok) |=> rsp_pend_q && (rkind_q == M_ACK))
    else $error("identity request not acknowledged");
  nak_answer_a: assert property (@(posedge clk) disable iff (!reset_n)
    (rx_req && rx_cmd != CMD_DISC_ID) |=> (rkind_q == M_NAK))
    else $error("unknown command not refused");
  busy_wait_a: assert property (@(posedge clk) disable iff (!reset_n)
    busy_done_s |=> quiet_s)
    else $error("retry before busy back-off");
  hdr_resv_a: assert property (@(posedge clk) disable iff (!reset_n)
    (id_hdr[22:16] == 7'h00) && (id_hdr[25:23] <= DFP_MAX))
    else $error("identity header reserved bits set");
endmodule // pdid_top

// ---- verification/pdid_partner.sv ----
module pdid_partner import pdid_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Beats coming from the block
  input wire logic tx_valid,
  output logic tx_ready,
  input wire pdid_tx_t tx_beat,
  output logic tx_crc_ok,
  output logic tx_crc_fail,
  // Messages going to the block
  output logic rx_valid,
  output pdid_rx_t rx_msg,
  output logic rsp_crc_sent
);
  timeunit 1ns;
  timeprecision 1ps;
  // Knobs set by the bench: refuse GoodCRC, stall the beat handshake
  logic crc_bad = 1'b0;
  logic slow = 1'b0;
  pdid_tx_t beats[$];
  int ends[$];
  int cyc = 0;
  int crc_wait = 0;

  // Free cycle count for spacing checks
  always @(posedge clk) cyc <= cyc + 1;

  // Idle receive lines until a message is sent
  initial begin
    rx_valid = 1'b0;
    rx_msg = '0;
    rsp_crc_sent = 1'b0;
  end

  // Take beats, then answer with a GoodCRC outcome a few cycles later
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_ready <= 1'b0;
      tx_crc_ok <= 1'b0;
      tx_crc_fail <= 1'b0;
      crc_wait <= 0;
    end else begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
      tx_crc_ok <= (crc_wait == 1) && !crc_bad;
      tx_crc_fail <= (crc_wait == 1) && crc_bad;
      crc_wait <= (crc_wait > 0) ? crc_wait - 1 : 0;
      if (tx_valid && tx_ready) begin
        beats.push_back(tx_beat);
        if (tx_beat.last) begin
          crc_wait <= 3;
          ends.push_back(cyc);
        end
      end
    end
  end

  // One message pulse; afterwards the lines show a changed pattern
  task automatic send(input logic cab, input logic [2:0] n, input logic [31:0] v,
                      input logic [31:0] o);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_msg <= '{cab, n, v, o};
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_msg <= ~rx_msg;
  endtask

  // Our GoodCRC to the block's response has gone out
  task automatic crc_sent;
    @(posedge clk);
    rsp_crc_sent <= 1'b1;
    @(posedge clk);
    rsp_crc_sent <= 1'b0;
  endtask
endmodule // pdid_partner

// ---- verification/tb_top.sv ----
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin err_total++; \
  $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module tb_top import pdid_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] SID = 16'h3C5A; // Arbitrary value
  logic clk, reset_n, reg_wr, reg_rd, tx_valid, tx_ready, tx_crc_ok, tx_crc_fail;
  logic rx_valid, rsp_crc_sent, cable_supply_on, soft_reset_req;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rdv;
  pdid_tx_t tx_beat;
  pdid_rx_t rx_msg;
  int err_total = 0;
  int comparisons = 0;
  int srst_cnt = 0;

  pdid_top #(.PROTO_SID(SID), .SETTLE_CYCLES(10), .RETRY_CYCLES(20), .BUSY_CYCLES(12),
    .LIMIT(3)) DUT (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_beat(tx_beat), .tx_crc_ok(tx_crc_ok),
    .tx_crc_fail(tx_crc_fail), .rx_valid(rx_valid), .rx_msg(rx_msg),
    .rsp_crc_sent(rsp_crc_sent), .cable_supply_on(cable_supply_on),
    .soft_reset_req(soft_reset_req));
  pdid_partner P (.clk(clk), .reset_n(reset_n), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_beat(tx_beat), .tx_crc_ok(tx_crc_ok), .tx_crc_fail(tx_crc_fail),
    .rx_valid(rx_valid), .rx_msg(rx_msg), .rsp_crc_sent(rsp_crc_sent));

  // Clock and soft reset pulse count
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) if (soft_reset_req === 1'b1) srst_cnt++;

  function automatic logic [31:0] hdr(logic [1:0] ct, logic [4:0] cmd);
    return {SID, 1'b1, 7'h00, ct, 1'b0, cmd};
  endfunction

  task automatic tally_and_finish;
    if (err_total == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Register bus master
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rdv = reg_rdata;
  endtask

  // Bounded wait for n complete messages at the partner
  task automatic wait_msg(input int n);
    int k;
    k = 0;
    while (P.ends.size() < n && k < 5000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 5000) begin
      err_total++;
      $display("unexpected message count expected %0d seen %0d", n, P.ends.size());
      tally_and_finish;
    end else begin
      repeat (6) @(posedge clk);
    end
  endtask
  task automatic clr;
    P.beats.delete();
    P.ends.delete();
  endtask

  // Reset values, write/readback, unmapped address
  task automatic t_regs;
    rd(REG_IDCFG);
    `CHK("idcfg reset", IDCFG_RST, rdv)
    rd(REG_CERT);
    `CHK("cert reset", 32'h0000_0000, rdv)
    wr(REG_CERT, 32'hCAFE_0001);
    rd(REG_CERT);
    `CHK("cert readback", 32'hCAFE_0001, rdv)
    wr(8'h1C, 32'hFFFF_FFFF);
    rd(8'h1C);
    `CHK("unmapped read", 32'h0000_0000, rdv)
  endtask

  // Acknowledge contents for every type code, surplus objects in request
  task automatic t_resp_types;
    logic [2:0] u, f, n;
    logic [31:0] exp;
    wr(REG_PROD, 32'h5678_0102);
    wr(REG_ADAPT, 32'h0BAD_F00D);
    wr(REG_CTRL, 32'h0000_0008);
    for (int i = 0; i < 8; i++) begin
      u = (i inside {0, 1, 2, 5}) ? 3'(i) : 3'h0;
      f = (i <= 4) ? 3'(i) : 3'h0;
      n = (u == 3'h5) ? 3'h5 : 3'h4;
      exp = {1'(i), 1'(i >> 1), u, 1'b1, f, 7'h00, 16'h1200 + 16'(i)};
      wr(REG_IDCFG, {1'(i), 1'(i >> 1), 3'(i), 1'b1, 3'(i), 7'h7F, 16'h1200 + 16'(i)});
      clr();
      P.send(1'b0, 3'h6, hdr(CT_INIT, CMD_DISC_ID), 32'hFFFF_FFFF);
      wait_msg(1);
      `CHK("ack header", hdr(CT_ACK, CMD_DISC_ID), P.beats[0].data)
      `CHK("ack count", n, P.beats[0].ndo)
      `CHK("beat total", 32'(n), 32'(P.beats.size()))
      `CHK("id header", exp, P.beats[1].data)
      `CHK("cert object", 32'hCAFE_0001, P.beats[2].data)
      `CHK("product object", 32'h5678_0102, P.beats[3].data)
      `CHK("last flag", 1'b1, P.beats[n - 1].last)
      if (n == 3'h5) `CHK("adapter object", 32'h0BAD_F00D, P.beats[4].data)
    end
  endtask

  // Non-modal port and unknown command both refused
  task automatic t_nak;
    wr(REG_IDCFG, 32'h1000_1234);
    clr();
    P.send(1'b0, 3'h1, hdr(CT_INIT, CMD_DISC_ID), 32'h0000_0000);
    wait_msg(1);
    `CHK("non-modal nak", hdr(CT_NAK, CMD_DISC_ID), P.beats[0].data)
    wr(REG_IDCFG, 32'h2C00_1234);
    clr();
    P.send(1'b0, 3'h1, hdr(CT_INIT, 5'h02), 32'h0000_0000);
    wait_msg(1);
    `CHK("unknown nak", hdr(CT_NAK, 5'h02), P.beats[0].data)
    `CHK("nak count", 3'h1, P.beats[0].ndo)
    clr();
    P.send(1'b0, 3'h1, hdr(CT_INIT, CMD_ATTN), 32'h0000_0000);
    P.send(1'b1, 3'h1, hdr(CT_INIT, CMD_DISC_ID), 32'h0000_0000);
    repeat (20) @(posedge clk);
    `CHK("ignored requests", 32'h0, 32'(P.ends.size()))
  endtask

  // Request on SOP, completion only after our GoodCRC
  task automatic t_init_sop;
    clr();
    wr(REG_CTRL, 32'h0000_0009);
    wait_msg(1);
    `CHK("request word", hdr(CT_INIT, CMD_DISC_ID), P.beats[0].data)
    `CHK("request count", 3'h1, P.beats[0].ndo)
    `CHK("request single", 32'h1, 32'(P.beats.size()))
    P.send(1'b0, 3'h4, hdr(CT_ACK, CMD_DISC_ID), 32'h8800_ABCD);
    rd(REG_STATUS);
    `CHK("early result", RES_NONE, rdv[6:4])
    P.crc_sent();
    repeat (3) @(posedge clk);
    rd(REG_STATUS);
    `CHK("final result", RES_ACK, rdv[6:4])
    rd(REG_PARTNER);
    `CHK("partner header", 32'h8800_ABCD, rdv)
  endtask

  // Busy answer, resend only after the back-off
  task automatic t_busy;
    int c0;
    clr();
    wr(REG_CTRL, 32'h0000_0009);
    wait_msg(1);
    P.send(1'b0, 3'h1, hdr(CT_BUSY, CMD_DISC_ID), 32'h0000_0000);
    P.crc_sent();
    c0 = P.cyc;
    wait_msg(2);
    `CHK("busy backoff", 1'b1, (P.ends[1] - c0 >= 12))
    P.send(1'b0, 3'h4, hdr(CT_ACK, CMD_DISC_ID), 32'h0000_0000);
    P.crc_sent();
    repeat (4) @(posedge clk);
    clr();
    wr(REG_CTRL, 32'h0000_0009);
    wait_msg(1);
    repeat (30) @(posedge clk);
    rd(REG_STATUS);
    `CHK("no answer", RES_TMO, rdv[6:4])
    `CHK("single try", 32'h1, 32'(P.ends.size()))
  endtask

  // Cable probe: settle wait, retries, no soft reset; SOP failure does reset
  task automatic t_cable;
    int c0;
    clr();
    P.slow = 1'b1;
    P.crc_bad = 1'b1;
    wr(REG_CTRL, 32'h0000_000F);
    repeat (40) @(posedge clk);
    `CHK("sent unpowered", 32'h0, 32'(P.ends.size()))
    cable_supply_on <= 1'b1;
    c0 = P.cyc;
    wait_msg(3);
    `CHK("settle wait", 1'b1, (P.ends[0] - c0 >= 10))
    `CHK("retry gap", 1'b1, (P.ends[1] - P.ends[0] >= 20))
    `CHK("cable target", 1'b1, P.beats[0].cable)
    repeat (200) @(posedge clk);
    `CHK("retry total", 32'h3, 32'(P.ends.size()))
    `CHK("no soft reset", 32'h0, 32'(srst_cnt))
    rd(REG_STATUS);
    `CHK("cable result", RES_NOCRC, rdv[6:4])
    clr();
    wr(REG_CTRL, 32'h0000_0009);
    wait_msg(1);
    `CHK("sop soft reset", 32'h1, 32'(srst_cnt))
    P.slow = 1'b0;
    P.crc_bad = 1'b0;
  endtask

  // Main sequence
  initial begin
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    cable_supply_on = 1'b0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_resp_types();
    t_nak();
    t_init_sop();
    t_busy();
    t_cable();
    tally_and_finish();
  end
endmodule // tb_top
